/* core_sw_model.sv */
// Software-side model that sets the divider and issues flash commands
module core_sw_model
  import flash_timing_pkg::*;
(
  // Clock and handshake
  input  wire logic sys_clk,
  input  wire logic cmd_ready,
  // Divider setup
  output logic      div_wr,
  output div_t      div_val,
  output logic      acc_err,
  // Command request
  output logic      cmd_valid,
  output op_t       cmd_op,
  output addr_t     cmd_addr
);
  timeunit 1ns;
  timeprecision 1ps;

  // Quiet levels from time zero
  initial begin
    div_wr = 1'b0;
    div_val = 10'h000;
    acc_err = 1'b0;
    cmd_valid = 1'b0;
    cmd_op = 2'h0;
    cmd_addr = 15'h0000;
  end

  // One divider write, optionally with the error flag raised
  task automatic write_div(input div_t v, input logic err);
    @(negedge sys_clk);
    acc_err = err;
    div_wr = 1'b1;
    div_val = v;
    @(negedge sys_clk);
    div_wr = 1'b0;
    acc_err = 1'b0;
    div_val = ~v;  // Released bus must not keep the old value
  endtask

  // Hold a request until ready is seen at a rising edge
  task automatic issue(input op_t op, input addr_t a);
    int n;
    @(negedge sys_clk);
    cmd_valid = 1'b1;
    cmd_op = op;
    cmd_addr = a;
    for (n = 0; n < 100000; n++) begin
      #1;
      if (cmd_ready === 1'b1) break;
      @(negedge sys_clk);
    end
    @(posedge sys_clk);
    @(negedge sys_clk);
    cmd_valid = 1'b0;
    cmd_op = ~op;
    cmd_addr = ~a;
  endtask

  // One-cycle request that is expected to be refused
  task automatic poke(input op_t op);
    @(negedge sys_clk);
    cmd_valid = 1'b1;
    cmd_op = op;
    @(negedge sys_clk);
    cmd_valid = 1'b0;
  endtask
endmodule

/* flash_timing_cfg.svh */
// Constants for the flash program and erase timing sequencer
`ifndef FLASH_TIMING_CFG_SVH
`define FLASH_TIMING_CFG_SVH

// Bus clock and allowed timing clock band, in kHz
`define SYS_CLK_KHZ     100000
`define TIMING_CLK_MIN_KHZ 150
`define TIMING_CLK_MAX_KHZ 200
// Divider ratio bounds in bus cycles per timing period
`define DIV_RATIO_MIN   ((`SYS_CLK_KHZ + `TIMING_CLK_MAX_KHZ - 1) / `TIMING_CLK_MAX_KHZ)
`define DIV_RATIO_MAX   (`SYS_CLK_KHZ / `TIMING_CLK_MIN_KHZ)

// Widths
`define DIV_W           10
`define ADDR_W          15
`define CNT_W           15
`define ROW_BITS        6
`define PAGE_BITS       9

// Divider reset value (period minus one)
`define DIV_RST         10'h000

// Command codes
`define OP_PROG         2'h0
`define OP_BURST        2'h1
`define OP_PAGE         2'h2
`define OP_MASS         2'h3

// Whole command lengths in timing periods; burst is the pulse of a continued byte only
`define TICKS_BYTE      15'd9
`define TICKS_BURST     15'd4
`define TICKS_PAGE      15'd4000
`define TICKS_MASS      15'd20000
// Pump switch-on and switch-off overhead in timing periods
`define TICKS_START     15'd3
`define TICKS_END       15'd2

`endif

/* flash_timing_pkg.sv */
// Types shared by the flash timing sequencer
package flash_timing_pkg;
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_START,
    ST_PULSE,
    ST_END
  } seq_e;
  typedef logic [1:0]  op_t;
  typedef logic [9:0]  div_t;
  typedef logic [14:0] addr_t;
  typedef logic [14:0] cnt_t;
endpackage

/* flash_timing_top.sv */
// Flash program and erase timing sequencer with burst pump hold
// Functional notes
// - No command accepted before divider written
// - Only first unblocked divider write takes effect
// - Divider write blocked while access error set
// - Pulses timed in whole timing-clock periods
// - Byte 9, page 4000, mass 20000 periods
// - Counts include start and end overhead
// - Pump on per command, off when done
// - Burst keeps pump if next byte queued, sequential, same row
// - Continued burst byte takes 4 periods
// - Rows are 64 bytes, A5..A0 select
// - Page erase acts on 512-byte page
module flash_timing_top
  import flash_timing_pkg::*;
(
  // Clock and reset
  input  wire logic SYS_CLK,
  input  wire logic RST,
  // Divider setup
  input  wire logic DIV_WR,
  input  wire div_t DIV_VAL,
  input  wire logic ACC_ERR,
  output logic      DIV_SET,
  output div_t      DIV_RATIO,
  // Command port
  input  wire logic CMD_VALID,
  input  wire op_t  CMD_OP,
  input  wire addr_t CMD_ADDR,
  output logic      CMD_READY,
  output logic      CMD_REJECT,
  // Array control and status
  output logic      PUMP_EN,
  output logic      BUSY,
  output addr_t     CUR_ADDR,
  output logic [5:0] ERASE_PAGE,
  output logic      OP_DONE,
  output logic      TIMING_TICK
);
  `include "flash_timing_cfg.svh"

  tick_if tif ();

  logic  div_set_q;   // Divider written once
  div_t  div_q;       // Period length minus one
  seq_e  state_q;     // Sequencer state
  seq_e  state_d;
  op_t   op_q;        // Command in progress
  addr_t addr_q;      // Address in progress
  cnt_t  cnt_q;       // Periods left in state, minus one
  cnt_t  cnt_d;
  logic  pend_v_q;    // Queued command present
  op_t   pend_op_q;
  addr_t pend_addr_q;
  logic  pump_q;
  logic  done_q;
  logic  reject_q;
  logic  tick;
  logic  last;        // Final period of current state
  logic  cont_ok;     // Burst may go on without pump off
  logic  take_idle;   // New command enters from idle
  logic  take_pend;   // Command queued behind a running one
  logic  launch;      // Leave idle this cycle

  // Length of the pulse portion for a fresh command
  function automatic cnt_t pulse_len(input op_t op);
    unique case (op)
      `OP_PROG, `OP_BURST: pulse_len = `TICKS_BYTE - `TICKS_START - `TICKS_END;
      `OP_PAGE:            pulse_len = `TICKS_PAGE - `TICKS_START - `TICKS_END;
      `OP_MASS:            pulse_len = `TICKS_MASS - `TICKS_START - `TICKS_END;
    endcase
  endfunction

  // Divider: first unblocked write wins, later ones are dropped
  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      div_set_q <= 1'b0;
      div_q     <= `DIV_RST;
    end else if (DIV_WR && !div_set_q && !ACC_ERR) begin
      div_set_q <= 1'b1;
      div_q     <= DIV_VAL;
    end
  end

  assign tif.enable  = div_set_q;
  assign tif.ratio   = div_q;
  assign tif.restart = launch;
  assign tick        = tif.tick;

  tick_gen u_tick (
    .clk (SYS_CLK),
    .rst (RST),
    .tif (tif)
  );

  // Handshake terms; nothing is taken before the divider is set
  assign take_idle = (state_q == ST_IDLE) && !pend_v_q && CMD_VALID && div_set_q;
  assign take_pend = (state_q != ST_IDLE) && (op_q == `OP_BURST) && !pend_v_q
                     && CMD_VALID && div_set_q;
  assign launch    = (state_q == ST_IDLE) && (take_idle || pend_v_q);
  assign CMD_READY = take_idle || take_pend;
  assign last      = tick && (cnt_q == 15'h0000);
  // Next byte must be sequential and not open a new row
  assign cont_ok   = pend_v_q && (pend_op_q == `OP_BURST)
                     && (pend_addr_q == addr_q + 15'h0001)
                     && (addr_q[`ROW_BITS-1:0] != 6'h3F);

  // Next state and period count
  always_comb begin
    state_d = state_q;
    cnt_d   = cnt_q;
    if (tick && cnt_q != 15'h0000) begin
      cnt_d = cnt_q - 15'h0001;
    end
    unique case (state_q)
      ST_IDLE: begin
        if (launch) begin
          state_d = ST_START;
          cnt_d   = `TICKS_START - 15'h0001;
        end
      end
      ST_START: begin
        if (last) begin
          state_d = ST_PULSE;
          cnt_d   = pulse_len(op_q) - 15'h0001;
        end
      end
      ST_PULSE: begin
        if (last && op_q == `OP_BURST && cont_ok) begin
          cnt_d = `TICKS_BURST - 15'h0001;
        end else if (last) begin
          state_d = ST_END;
          cnt_d   = `TICKS_END - 15'h0001;
        end
      end
      ST_END: begin
        if (last) begin
          state_d = ST_IDLE;
        end
      end
    endcase
  end

  // Sequencer registers
  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      state_q <= ST_IDLE;
      cnt_q   <= 15'h0000;
    end else begin
      state_q <= state_d;
      cnt_q   <= cnt_d;
    end
  end

  // Current command: from port, from queue, or burst continuation
  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      op_q   <= `OP_PROG;
      addr_q <= 15'h0000;
    end else if (take_idle) begin
      op_q   <= CMD_OP;
      addr_q <= CMD_ADDR;
    end else if (launch || (state_q == ST_PULSE && last && op_q == `OP_BURST && cont_ok)) begin
      op_q   <= pend_op_q;
      addr_q <= pend_addr_q;
    end
  end

  // One-deep queue behind a running burst; its hand-off clears it
  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      pend_v_q    <= 1'b0;
      pend_op_q   <= `OP_PROG;
      pend_addr_q <= 15'h0000;
    end else if (take_pend) begin
      pend_v_q    <= 1'b1;
      pend_op_q   <= CMD_OP;
      pend_addr_q <= CMD_ADDR;
    end else if (launch || (state_q == ST_PULSE && last && op_q == `OP_BURST && cont_ok)) begin
      pend_v_q    <= 1'b0;
    end
  end

  // Pump follows the sequencer, so it drops in the idle gap
  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      pump_q <= 1'b0;
    end else begin
      pump_q <= (state_d != ST_IDLE);
    end
  end

  // Status pulses
  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      done_q   <= 1'b0;
      reject_q <= 1'b0;
    end else begin
      done_q   <= (state_q == ST_PULSE) && last;
      reject_q <= CMD_VALID && !div_set_q;
    end
  end

  assign DIV_SET     = div_set_q;
  assign DIV_RATIO   = div_q;
  assign CMD_REJECT  = reject_q;
  assign PUMP_EN     = pump_q;
  assign BUSY        = (state_q != ST_IDLE);
  assign CUR_ADDR    = addr_q;
  assign ERASE_PAGE  = addr_q[`ADDR_W-1:`PAGE_BITS];
  assign OP_DONE     = done_q;
  assign TIMING_TICK = tick;

  // Helper: periods spent since leaving idle, and bursts chained
  cnt_t hlp_ticks_q;
  logic hlp_chain_q;
  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      hlp_ticks_q <= 15'h0000;
      hlp_chain_q <= 1'b0;
    end else if (launch) begin
      hlp_ticks_q <= 15'h0000;
      hlp_chain_q <= 1'b0;
    end else if (state_q != ST_IDLE) begin
      if (tick) begin
        hlp_ticks_q <= hlp_ticks_q + 15'h0001;
      end
      if (state_q == ST_PULSE && last && cont_ok && op_q == `OP_BURST) begin
        hlp_chain_q <= 1'b1;
      end
    end
  end

  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (RST);

  a_no_cmd_unset: assert property (!div_set_q |-> !CMD_READY && state_q == ST_IDLE)
    else $error("command accepted before divider set");
  a_div_write_once: assert property (div_set_q |=> $stable(div_q) && div_set_q)
    else $error("divider changed after first write");
  a_div_err_block: assert property (!div_set_q && ACC_ERR |=> !div_set_q)
    else $error("divider taken while access error set");
  a_ticks_only: assert property (!tick && state_q != ST_IDLE
                                 |=> cnt_q == $past(cnt_q) || state_q != $past(state_q))
    else $error("period count moved without a tick");
  a_byte_total: assert property (state_q == ST_END && last && !hlp_chain_q
                                 && (op_q == `OP_PROG || op_q == `OP_BURST)
                                 |-> hlp_ticks_q == `TICKS_BYTE - 15'h0001)
    else $error("byte program not nine periods");
  a_page_total: assert property (state_q == ST_END && last && op_q == `OP_PAGE
                                 |-> hlp_ticks_q == `TICKS_PAGE - 15'h0001)
    else $error("page erase length wrong");
  a_mass_total: assert property (state_q == ST_END && last && op_q == `OP_MASS
                                 |-> hlp_ticks_q == `TICKS_MASS - 15'h0001)
    else $error("mass erase length wrong");
  a_pump_busy: assert property (##1 PUMP_EN == (state_q != ST_IDLE))
    else $error("pump does not follow command");
  a_pump_off_end: assert property (state_q == ST_END && last |=> !PUMP_EN)
    else $error("pump left on after command end");
  a_burst_hold: assert property (state_q == ST_PULSE && last
                                 && op_q == `OP_BURST && cont_ok
                                 |=> state_q == ST_PULSE && PUMP_EN
                                 && cnt_q == `TICKS_BURST - 15'h0001)
    else $error("burst continuation dropped");
  a_row_break: assert property (state_q == ST_PULSE && last
                                && addr_q[5:0] == 6'h3F
                                |=> state_q == ST_END)
    else $error("burst crossed a row");

  c_byte: cover property (state_q == ST_END && last && op_q == `OP_PROG);
  c_burst_chain: cover property (state_q == ST_PULSE && last && cont_ok && op_q == `OP_BURST);
  c_page: cover property (state_q == ST_END && last && op_q == `OP_PAGE);
  c_reject: cover property (CMD_REJECT);
endmodule

/* test_flash_timing_top.sv */
// Self-checking bench for the flash program and erase sequencer
module test_flash_timing_top;
  import flash_timing_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  `include "flash_timing_cfg.svh"

  logic       SYS_CLK = 1'b0;   // Bus clock
  logic       RST = 1'b1;       // Async reset
  logic       DIV_WR, ACC_ERR, CMD_VALID;
  div_t       DIV_VAL, DIV_RATIO;
  op_t        CMD_OP;
  addr_t      CMD_ADDR, CUR_ADDR;
  logic       DIV_SET, CMD_READY, CMD_REJECT, PUMP_EN, BUSY, OP_DONE, TIMING_TICK;
  logic [5:0] ERASE_PAGE;
  int         n_errors = 0;     // Mismatches
  int         checks = 0;       // Comparisons
  int         ticks = 0;        // Periods seen while busy
  int         dones = 0;        // Done pulses
  int         pfalls = 0;       // Pump switch-offs
  int         bad_pump = 0;     // Busy cycles without pump
  int         busy_cyc = 0;     // Bus cycles spent busy
  logic       pump_q = 1'b0;    // Pump level one cycle back

  // Bus clock, 10 ns period
  always #5 SYS_CLK = ~SYS_CLK;

  flash_timing_top i_flash_timing_top (.SYS_CLK(SYS_CLK), .RST(RST), .DIV_WR(DIV_WR),
    .DIV_VAL(DIV_VAL), .ACC_ERR(ACC_ERR), .DIV_SET(DIV_SET), .DIV_RATIO(DIV_RATIO),
    .CMD_VALID(CMD_VALID), .CMD_OP(CMD_OP), .CMD_ADDR(CMD_ADDR), .CMD_READY(CMD_READY),
    .CMD_REJECT(CMD_REJECT), .PUMP_EN(PUMP_EN), .BUSY(BUSY), .CUR_ADDR(CUR_ADDR),
    .ERASE_PAGE(ERASE_PAGE), .OP_DONE(OP_DONE), .TIMING_TICK(TIMING_TICK));

  core_sw_model i_core_sw_model (.sys_clk(SYS_CLK), .cmd_ready(CMD_READY), .div_wr(DIV_WR),
    .div_val(DIV_VAL), .acc_err(ACC_ERR), .cmd_valid(CMD_VALID), .cmd_op(CMD_OP),
    .cmd_addr(CMD_ADDR));

  // Monitor at the falling edge, where outputs are settled
  always @(negedge SYS_CLK) begin
    if (BUSY === 1'b1 && TIMING_TICK === 1'b1) ticks++;
    if (OP_DONE === 1'b1) dones++;
    if (pump_q === 1'b1 && PUMP_EN !== 1'b1) pfalls++;
    if (BUSY === 1'b1 && PUMP_EN !== 1'b1) bad_pump++;
    if (BUSY === 1'b1) busy_cyc++;
    pump_q <= PUMP_EN;
  end

  // Single compare, counted either way
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // Wait until the block has been idle a few cycles, bounded
  task automatic wait_idle();
    int q, n;
    q = 0;
    for (n = 0; n < 60000 && q < 4; n++) begin
      @(negedge SYS_CLK);
      q = (BUSY === 1'b0) ? q + 1 : 0;
    end
    chk(16'(q), 16'd4);
  endtask

  // Snapshot of the activity counters, taken while idle
  task automatic snap(output int t0, d0, p0, b0);
    t0 = ticks;
    d0 = dones;
    p0 = pfalls;
    b0 = busy_cyc;
  endtask

  // Compare activity counters against a snapshot
  task automatic chk_run(input int t0, d0, p0, et, ed, ep);
    chk(16'(ticks - t0), 16'(et));
    chk(16'(dones - d0), 16'(ed));
    chk(16'(pfalls - p0), 16'(ep));
  endtask

  // Outputs after reset, then a request before the divider is set
  task automatic t_refuse();
    chk(16'(CMD_READY), 16'h0000);
    chk(16'(DIV_SET), 16'h0000);
    i_core_sw_model.poke(`OP_PAGE);
    chk(16'(CMD_REJECT), 16'h0001);
    @(negedge SYS_CLK);
    chk(16'(BUSY), 16'h0000);
  endtask

  // Blocked, first and ignored divider writes; short period keeps the run brief
  task automatic t_div();
    i_core_sw_model.write_div(10'h001, 1'b1);
    chk(16'(DIV_SET), 16'h0000);
    i_core_sw_model.write_div(10'h001, 1'b0);
    chk(16'(DIV_SET), 16'h0001);
    i_core_sw_model.write_div(10'h005, 1'b0);
    chk(16'(DIV_RATIO), 16'h0001);
  endtask

  // Byte, page and mass commands each with full overhead; a period is two cycles
  task automatic t_single();
    int t0, d0, p0, b0;
    snap(t0, d0, p0, b0);
    i_core_sw_model.issue(`OP_PROG, 15'h0123);
    wait_idle();
    chk_run(t0, d0, p0, 9, 1, 1);
    chk(16'(busy_cyc - b0), 16'd18);
    snap(t0, d0, p0, b0);
    i_core_sw_model.issue(`OP_PAGE, 15'h5A00);
    chk(16'(ERASE_PAGE), 16'h002D);
    chk(16'(CUR_ADDR), 16'h5A00);
    wait_idle();
    chk_run(t0, d0, p0, 4000, 1, 1);
    chk(16'(busy_cyc - b0), 16'd8000);
    snap(t0, d0, p0, b0);
    i_core_sw_model.issue(`OP_MASS, 15'h7FFF);
    wait_idle();
    chk_run(t0, d0, p0, 20000, 1, 1);
    chk(16'(busy_cyc - b0), 16'd40000);
    chk(16'(bad_pump), 16'h0000);
  endtask

  // Burst across a row end, then a non-sequential queued byte
  task automatic t_burst();
    int t0, d0, p0, b0;
    snap(t0, d0, p0, b0);
    i_core_sw_model.issue(`OP_BURST, 15'h003E);
    i_core_sw_model.issue(`OP_BURST, 15'h003F);
    i_core_sw_model.issue(`OP_BURST, 15'h0040);
    i_core_sw_model.issue(`OP_BURST, 15'h0045);
    wait_idle();
    chk(16'(ticks - t0), 16'd31);
    chk(16'(dones - d0), 16'd4);
    chk(16'(pfalls - p0), 16'd3);
    chk(16'(bad_pump), 16'h0000);
  endtask

  // Mid-run reset, then an in-band divider and one byte at true speed
  task automatic t_band();
    int t0, d0, p0, b0;
    RST = 1'b1;
    repeat (3) @(negedge SYS_CLK);
    RST = 1'b0;
    chk(16'(DIV_SET), 16'h0000);
    chk(16'(DIV_RATIO), 16'h0000);
    i_core_sw_model.write_div(10'(`DIV_RATIO_MIN - 1), 1'b0);
    chk(16'(DIV_RATIO), 16'(`DIV_RATIO_MIN - 1));
    snap(t0, d0, p0, b0);
    i_core_sw_model.issue(`OP_PROG, 15'h0241);
    wait_idle();
    chk_run(t0, d0, p0, 9, 1, 1);
    chk(16'(busy_cyc - b0), 16'(9 * `DIV_RATIO_MIN));
  endtask

  // Report counts and verdict, then stop
  task automatic finish_test();
    $display("errors %0d checks %0d", n_errors, checks);
    if (n_errors == 0 && checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  // Main sequence
  initial begin
    repeat (3) @(posedge SYS_CLK);
    @(negedge SYS_CLK);
    RST = 1'b0;
    t_refuse();
    t_div();
    t_single();
    t_burst();
    t_band();
    finish_test();
  end

  // Watchdog well beyond the expected 53k cycles
  initial begin
    #700000;
    n_errors++;
    finish_test();
  end
endmodule

/* tick_gen.sv */
// Timing period generator derived from the bus clock
module tick_gen
  import flash_timing_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Sequencer side
  tick_if.gen      tif
);
  `include "flash_timing_cfg.svh"

  div_t cnt_q;  // Bus cycles into current period

  // Period counter, restarted so every command sees whole periods
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_q <= `DIV_RST;
    end else if (!tif.enable || tif.restart) begin
      cnt_q <= `DIV_RST;
    end else if (cnt_q == tif.ratio) begin
      cnt_q <= `DIV_RST;
    end else begin
      cnt_q <= cnt_q + 10'h001;
    end
  end

  // Pulse at end of each full period
  assign tif.tick = tif.enable && !tif.restart && (cnt_q == tif.ratio);

  a_tick_spacing: assert property (@(posedge clk) disable iff (rst)
    tif.tick |=> !tif.tick || (tif.ratio == `DIV_RST))
    else $error("timing ticks closer than one period");
endmodule

/* tick_if.sv */
// Carrier between the sequencer and its timing period generator
interface tick_if;
  import flash_timing_pkg::*;
  logic enable;   // Divider has been set
  logic restart;  // Realign period to a command start
  div_t ratio;    // Period length minus one
  logic tick;     // One bus cycle per timing period

  modport gen (input enable, input restart, input ratio, output tick);
  modport use_tick (output enable, output restart, output ratio, input tick);
endinterface
